/* File: rtl/aafr_regs.sv */
// Summary of operation
// RULE1 - low averaging register maps lanes one to four
// RULE2 - high averaging register maps lanes five to eight
// RULE3 - channel one filter register clears on reset
// RULE4 - bit fourteen enables channel one high-pass
// RULE5 - bits thirteen to ten set high-pass corner
// RULE6 - bits nine to seven pick filter kind
// RULE7 - bits six to four set decimation factor
// RULE8 - bit two selects the odd-tap filter
// RULE9 - bit zero puts filter in path
// RULE10 - lane selectors act only when globally enabled
// RULE11 - software writes zero to reserved bits
`default_nettype none

module aafr_regs
	import aafr_pkg::*;
(
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  rst,
	// axi4-lite write address
	input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	// axi4-lite write data
	input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,
	input  wire logic [AXI_STRB_W-1:0] s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	// axi4-lite write response
	output logic      [1:0]            s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	// axi4-lite read address
	input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	// axi4-lite read data
	output logic      [AXI_DATA_W-1:0] s_axi_rdata,
	output logic      [1:0]            s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// averaging configuration
	output logic                       global_averaging_enable,
	output var aafr_lanes_t            lane_averaging_select,
	output var aafr_lanes_t            lane_averaging_effective,
	// channel one filter configuration
	output var aafr_ch1_cfg_t          ch1_cfg
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	aafr_state_t      state_r;
	aafr_state_t      state_nxt;
	logic             wr_go;
	aafr_sel_t        wr_sel;
	aafr_sel_t        rd_sel;
	logic [REG_W-1:0] wr_old;
	logic [REG_W-1:0] wr_mask;
	logic [REG_W-1:0] wr_new;
	logic [REG_W-1:0] rd_val;
	logic [REG_W-1:0] lanes_vec;
	aafr_lanes_t      lanes_gated;

	// ----------------------------------------------------------------
	// handshakes
	// ----------------------------------------------------------------
	assign s_axi_awready = !state_r.aw_full;
	assign s_axi_wready  = !state_r.w_full;
	assign s_axi_arready = !state_r.r_valid;
	assign s_axi_bvalid  = state_r.b_valid;
	assign s_axi_bresp   = state_r.b_resp;
	assign s_axi_rvalid  = state_r.r_valid;
	assign s_axi_rdata   = state_r.r_data;
	assign s_axi_rresp   = state_r.r_resp;

	// write commits once address and data are both held and no write response is pending
	assign wr_go  = state_r.aw_full && state_r.w_full && !state_r.b_valid;
	assign wr_sel = aafr_decode(state_r.aw_addr);
	assign rd_sel = aafr_decode(s_axi_araddr);

	// ----------------------------------------------------------------
	// field views of the stored registers
	// ----------------------------------------------------------------
	always_comb
	begin
		lanes_vec = '0;
		for (int i = 0; i < LANES / 2; i++)
		begin
			lanes_vec[SEL_W*i +: SEL_W] =
				state_r.avg_low[LANE_STEP*i +: SEL_W]; // RULE1
			lanes_vec[SEL_W*(i+LANES/2) +: SEL_W] =
				state_r.avg_high[LANE_STEP*i +: SEL_W]; // RULE2
		end
	end

	assign lane_averaging_select   = lanes_vec;
	assign lane_averaging_effective = state_r.eff;
	assign global_averaging_enable = state_r.glob[GLOBAL_AVG_EN_POS];

	assign ch1_cfg.ch1_highpass_enable =
		state_r.ch1[CH1_HPF_EN_POS]; // RULE4
	assign ch1_cfg.ch1_highpass_corner =
		state_r.ch1[CH1_CORNER_LSB +: CH1_CORNER_W]; // RULE5
	assign ch1_cfg.ch1_filter_kind =
		state_r.ch1[CH1_KIND_LSB +: CH1_KIND_W]; // RULE6
	assign ch1_cfg.ch1_decimation_factor =
		state_r.ch1[CH1_DEC_LSB +: CH1_DEC_W]; // RULE7
	assign ch1_cfg.ch1_odd_tap_select =
		state_r.ch1[CH1_ODD_POS]; // RULE8
	assign ch1_cfg.ch1_filter_in_path =
		state_r.ch1[CH1_PATH_POS]; // RULE9

	// ----------------------------------------------------------------
	// averaging gate and write merge
	// ----------------------------------------------------------------
	aafr_avg_gate u_gate (
		.lanes_enable (global_averaging_enable),
		.lanes_in     (lanes_vec),
		.lanes_out    (lanes_gated)
	);

	always_comb
	begin
		wr_old  = '0;
		wr_mask = '0;
		unique case (wr_sel)
			SEL_GLOBAL:
			begin
				wr_old  = state_r.glob;
				wr_mask = GLOBAL_WR_MASK;
			end
			SEL_AVG_LOW:
			begin
				wr_old  = state_r.avg_low;
				wr_mask = AVG_WR_MASK;
			end
			SEL_AVG_HIGH:
			begin
				wr_old  = state_r.avg_high;
				wr_mask = AVG_WR_MASK;
			end
			SEL_CH1:
			begin
				wr_old  = state_r.ch1;
				wr_mask = CH1_WR_MASK; // RULE11
			end
			SEL_STATUS, SEL_NONE:
			begin
				wr_old  = '0;
				wr_mask = '0;
			end
		endcase
	end

	aafr_wmerge u_merge (
		.old_val (wr_old),
		.wr_data (state_r.w_data[REG_W-1:0]),
		.wr_strb (state_r.w_strb[REG_STRB_W-1:0]),
		.wr_mask (wr_mask),
		.new_val (wr_new)
	);

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb
	begin
		rd_val = '0;
		unique case (rd_sel)
			SEL_GLOBAL:   rd_val = state_r.glob;
			SEL_AVG_LOW:  rd_val = state_r.avg_low;
			SEL_AVG_HIGH: rd_val = state_r.avg_high;
			SEL_CH1:      rd_val = state_r.ch1;
			SEL_STATUS:   rd_val = state_r.eff;
			SEL_NONE:     rd_val = '0;
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		if (s_axi_awvalid && s_axi_awready)
		begin
			state_nxt.aw_full = 1'b1;
			state_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			state_nxt.w_full = 1'b1;
			state_nxt.w_data = s_axi_wdata;
			state_nxt.w_strb = s_axi_wstrb;
		end
		if (state_r.b_valid && s_axi_bready)
			state_nxt.b_valid = 1'b0;
		if (wr_go)
		begin
			state_nxt.aw_full = 1'b0;
			state_nxt.w_full  = 1'b0;
			state_nxt.b_valid = 1'b1;
			state_nxt.b_resp  = RESP_OKAY;
			unique case (wr_sel)
				SEL_GLOBAL:   state_nxt.glob     = wr_new;
				SEL_AVG_LOW:  state_nxt.avg_low  = wr_new; // RULE1
				SEL_AVG_HIGH: state_nxt.avg_high = wr_new; // RULE2
				SEL_CH1:      state_nxt.ch1      = wr_new;
				SEL_STATUS, SEL_NONE:
					state_nxt.b_resp = RESP_SLVERR;
			endcase
		end
		if (s_axi_arvalid && s_axi_arready)
		begin
			state_nxt.r_valid = 1'b1;
			state_nxt.r_data  = {{(AXI_DATA_W-REG_W){1'b0}}, rd_val};
			state_nxt.r_resp  = (rd_sel == SEL_NONE) ? RESP_SLVERR
				: RESP_OKAY;
		end
		else if (state_r.r_valid && s_axi_rready)
		begin
			state_nxt.r_valid = 1'b0;
		end
		state_nxt.eff = lanes_gated; // RULE10
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state_r          <= '0;
			state_r.glob     <= GLOBAL_RESET;
			state_r.avg_low  <= AVG_RESET;
			state_r.avg_high <= AVG_RESET;
			state_r.ch1      <= CH1_RESET; // RULE3
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	logic wr_both;
	assign wr_both = wr_go && (state_r.w_strb[REG_STRB_W-1:0] == 2'h3);

	a_lane_low_map: assert property ( // RULE1
		wr_both && wr_sel == SEL_AVG_LOW |=>
			lane_averaging_select.lane4_averaging_select
				== $past(state_r.w_data[10:9]) &&
			lane_averaging_select.lane3_averaging_select
				== $past(state_r.w_data[7:6]) &&
			lane_averaging_select.lane2_averaging_select
				== $past(state_r.w_data[4:3]) &&
			lane_averaging_select.lane1_averaging_select
				== $past(state_r.w_data[1:0]))
		else $error("low averaging lanes mismatch write");

	a_lane_high_map: assert property ( // RULE2
		wr_both && wr_sel == SEL_AVG_HIGH |=>
			lane_averaging_select.lane8_averaging_select
				== $past(state_r.w_data[10:9]) &&
			lane_averaging_select.lane7_averaging_select
				== $past(state_r.w_data[7:6]) &&
			lane_averaging_select.lane6_averaging_select
				== $past(state_r.w_data[4:3]) &&
			lane_averaging_select.lane5_averaging_select
				== $past(state_r.w_data[1:0]))
		else $error("high averaging lanes mismatch write");

	a_ch1_reset_zero: assert property ( // RULE3
		$past(rst) |-> ch1_cfg == '0 && state_r.ch1 == 16'h0000)
		else $error("channel one filter not zero after reset");

	a_hpf_enable_bit: assert property ( // RULE4
		wr_both && wr_sel == SEL_CH1 |=>
			ch1_cfg.ch1_highpass_enable == $past(state_r.w_data[14]))
		else $error("high-pass enable does not follow bit 14");

	a_hpf_corner_field: assert property ( // RULE5
		wr_both && wr_sel == SEL_CH1 |=>
			ch1_cfg.ch1_highpass_corner == $past(state_r.w_data[13:10]))
		else $error("high-pass corner does not follow bits 13:10");

	a_filter_kind_field: assert property ( // RULE6
		wr_both && wr_sel == SEL_CH1 |=>
			ch1_cfg.ch1_filter_kind == $past(state_r.w_data[9:7]))
		else $error("filter kind does not follow bits 9:7");

	a_decim_field: assert property ( // RULE7
		wr_both && wr_sel == SEL_CH1 |=>
			ch1_cfg.ch1_decimation_factor == $past(state_r.w_data[6:4]))
		else $error("decimation does not follow bits 6:4");

	a_odd_tap_bit: assert property ( // RULE8
		wr_both && wr_sel == SEL_CH1 |=>
			ch1_cfg.ch1_odd_tap_select == $past(state_r.w_data[2]))
		else $error("odd-tap select does not follow bit 2");

	a_filter_path_bit: assert property ( // RULE9
		wr_both && wr_sel == SEL_CH1 |=>
			ch1_cfg.ch1_filter_in_path == $past(state_r.w_data[0]))
		else $error("filter in path does not follow bit 0");

	a_avg_gate_out: assert property ( // RULE10
		!$past(rst) |->
			lane_averaging_effective == ($past(global_averaging_enable)
				? $past(lane_averaging_select) : '0))
		else $error("effective averaging not gated by enable");

	a_write_resp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
			&& $stable(s_axi_bresp))
		else $error("write response dropped before taken");

	a_read_resp_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
			&& $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read response changed before taken");

	a_refused_write_kept: assert property (
		wr_go && (wr_sel == SEL_NONE || wr_sel == SEL_STATUS) |=>
			$stable(state_r.glob) && $stable(state_r.avg_low) &&
			$stable(state_r.avg_high) && $stable(state_r.ch1) &&
			s_axi_bresp == RESP_SLVERR)
		else $error("refused write changed a register");

	a_reserved_bits_zero: assert property ( // RULE11
		(state_r.avg_low & ~AVG_WR_MASK) == '0 &&
			(state_r.avg_high & ~AVG_WR_MASK) == '0 &&
			(state_r.ch1 & ~CH1_WR_MASK) == '0)
		else $error("reserved register bit held a one");

	c_ch1_write: cover property (wr_go && wr_sel == SEL_CH1);
	c_status_read: cover property (
		s_axi_arvalid && s_axi_arready && rd_sel == SEL_STATUS);
	c_avg_live: cover property (
		global_averaging_enable && lane_averaging_effective != '0);
	c_same_cycle: cover property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready);

endmodule

`default_nettype wire

/* File: include/aafr_pkg.sv */
`default_nettype none

package aafr_pkg;

	// ----------------------------------------------------------------
	// bus and register geometry
	// ----------------------------------------------------------------
	localparam int unsigned AXI_ADDR_W = 8;
	localparam int unsigned AXI_DATA_W = 32;
	localparam int unsigned AXI_STRB_W = 4;
	localparam int unsigned REG_W      = 16;
	localparam int unsigned REG_STRB_W = 2;
	localparam int unsigned IDX_W      = 6;
	localparam int unsigned LANES      = 8;
	localparam int unsigned SEL_W      = 2;
	localparam int unsigned LANE_STEP  = 3;

	// ----------------------------------------------------------------
	// register indices, byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_GLOBAL_CTRL = 6'h29;
	localparam logic [IDX_W-1:0] IDX_AVG_LOW     = 6'h2C;
	localparam logic [IDX_W-1:0] IDX_AVG_HIGH    = 6'h2D;
	localparam logic [IDX_W-1:0] IDX_CH1_FILTER  = 6'h2E;
	localparam logic [IDX_W-1:0] IDX_AVG_STATUS  = 6'h3F;

	// ----------------------------------------------------------------
	// writable bits and reset values
	// ----------------------------------------------------------------
	localparam logic [REG_W-1:0] GLOBAL_WR_MASK = 16'h0001;
	localparam logic [REG_W-1:0] AVG_WR_MASK    = 16'h06DB;
	localparam logic [REG_W-1:0] CH1_WR_MASK    = 16'h7FF5;
	localparam logic [REG_W-1:0] GLOBAL_RESET   = 16'h0000;
	localparam logic [REG_W-1:0] AVG_RESET      = 16'h0000;
	localparam logic [REG_W-1:0] CH1_RESET      = 16'h0000;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned GLOBAL_AVG_EN_POS = 0;
	localparam int unsigned CH1_HPF_EN_POS    = 14;
	localparam int unsigned CH1_CORNER_LSB    = 10;
	localparam int unsigned CH1_CORNER_W      = 4;
	localparam int unsigned CH1_KIND_LSB      = 7;
	localparam int unsigned CH1_KIND_W        = 3;
	localparam int unsigned CH1_DEC_LSB       = 4;
	localparam int unsigned CH1_DEC_W         = 3;
	localparam int unsigned CH1_ODD_POS       = 2;
	localparam int unsigned CH1_PATH_POS      = 0;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [SEL_W-1:0] lane8_averaging_select;
		logic [SEL_W-1:0] lane7_averaging_select;
		logic [SEL_W-1:0] lane6_averaging_select;
		logic [SEL_W-1:0] lane5_averaging_select;
		logic [SEL_W-1:0] lane4_averaging_select;
		logic [SEL_W-1:0] lane3_averaging_select;
		logic [SEL_W-1:0] lane2_averaging_select;
		logic [SEL_W-1:0] lane1_averaging_select;
	} aafr_lanes_t;

	typedef struct packed {
		logic                    ch1_highpass_enable;
		logic [CH1_CORNER_W-1:0] ch1_highpass_corner;
		logic [CH1_KIND_W-1:0]   ch1_filter_kind;
		logic [CH1_DEC_W-1:0]    ch1_decimation_factor;
		logic                    ch1_odd_tap_select;
		logic                    ch1_filter_in_path;
	} aafr_ch1_cfg_t;

	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_GLOBAL,
		SEL_AVG_LOW,
		SEL_AVG_HIGH,
		SEL_CH1,
		SEL_STATUS
	} aafr_sel_t;

	typedef struct packed {
		logic                  aw_full;
		logic [AXI_ADDR_W-1:0] aw_addr;
		logic                  w_full;
		logic [AXI_DATA_W-1:0] w_data;
		logic [AXI_STRB_W-1:0] w_strb;
		logic                  b_valid;
		logic [1:0]            b_resp;
		logic                  r_valid;
		logic [AXI_DATA_W-1:0] r_data;
		logic [1:0]            r_resp;
		logic [REG_W-1:0]      glob;
		logic [REG_W-1:0]      avg_low;
		logic [REG_W-1:0]      avg_high;
		logic [REG_W-1:0]      ch1;
		aafr_lanes_t           eff;
	} aafr_state_t;

	// byte address to register select
	function automatic aafr_sel_t aafr_decode(
		input logic [AXI_ADDR_W-1:0] addr
	);
		logic [IDX_W-1:0] idx;
		idx = addr[AXI_ADDR_W-1:2];
		case (idx)
			IDX_GLOBAL_CTRL: return SEL_GLOBAL;
			IDX_AVG_LOW:     return SEL_AVG_LOW;
			IDX_AVG_HIGH:    return SEL_AVG_HIGH;
			IDX_CH1_FILTER:  return SEL_CH1;
			IDX_AVG_STATUS:  return SEL_STATUS;
			default:         return SEL_NONE;
		endcase
	endfunction

endpackage

`default_nettype wire

/* File: rtl/aafr_wmerge.sv */
`default_nettype none

module aafr_wmerge
	import aafr_pkg::*;
(
	// current value and write
	input  wire logic [REG_W-1:0]      old_val,
	input  wire logic [REG_W-1:0]      wr_data,
	input  wire logic [REG_STRB_W-1:0] wr_strb,
	input  wire logic [REG_W-1:0]      wr_mask,
	// merged value
	output logic      [REG_W-1:0]      new_val
);

	// ----------------------------------------------------------------
	// byte-lane merge, reserved bits forced to zero
	// ----------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < REG_W; i++)
		begin
			if (!wr_mask[i])
				new_val[i] = 1'b0; // RULE11
			else if (wr_strb[i/8])
				new_val[i] = wr_data[i];
			else
				new_val[i] = old_val[i];
		end
	end

endmodule

`default_nettype wire

/* File: rtl/aafr_avg_gate.sv */
`default_nettype none

module aafr_avg_gate
	import aafr_pkg::*;
(
	// stored selectors and global enable
	input  wire logic        lanes_enable,
	input  wire aafr_lanes_t lanes_in,
	// selectors in force
	output var  aafr_lanes_t lanes_out
);

	// ----------------------------------------------------------------
	// averaging off on every lane unless globally enabled
	// ----------------------------------------------------------------
	always_comb
	begin
		lanes_out = lanes_enable ? lanes_in : '0; // RULE10
	end

endmodule

`default_nettype wire

/* File: sim/tb.sv */
`default_nettype none

module tb
	import aafr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic                  mclk;
	logic                  rst;
	logic [AXI_ADDR_W-1:0] s_axi_awaddr;
	logic                  s_axi_awvalid;
	logic                  s_axi_awready;
	logic [AXI_DATA_W-1:0] s_axi_wdata;
	logic [AXI_STRB_W-1:0] s_axi_wstrb;
	logic                  s_axi_wvalid;
	logic                  s_axi_wready;
	logic [1:0]            s_axi_bresp;
	logic                  s_axi_bvalid;
	logic                  s_axi_bready;
	logic [AXI_ADDR_W-1:0] s_axi_araddr;
	logic                  s_axi_arvalid;
	logic                  s_axi_arready;
	logic [AXI_DATA_W-1:0] s_axi_rdata;
	logic [1:0]            s_axi_rresp;
	logic                  s_axi_rvalid;
	logic                  s_axi_rready;
	logic                  global_averaging_enable;
	aafr_lanes_t           lane_averaging_select;
	aafr_lanes_t           lane_averaging_effective;
	aafr_ch1_cfg_t         ch1_cfg;
	int                    fails;
	int                    num_checks;
	logic [15:0]           lo_tab [2] = '{16'hFFFF, 16'hFDF5};
	logic [15:0]           hi_tab [2] = '{16'hFFFF, 16'hFF7E};
	logic [15:0]           ch1_tab [4] = '{16'hFFFF, 16'h8000, 16'h154E,
		16'h6AB1};

	aafr_regs uut (
		.mclk                     (mclk),
		.rst                      (rst),
		.s_axi_awaddr             (s_axi_awaddr),
		.s_axi_awvalid            (s_axi_awvalid),
		.s_axi_awready            (s_axi_awready),
		.s_axi_wdata              (s_axi_wdata),
		.s_axi_wstrb              (s_axi_wstrb),
		.s_axi_wvalid             (s_axi_wvalid),
		.s_axi_wready             (s_axi_wready),
		.s_axi_bresp              (s_axi_bresp),
		.s_axi_bvalid             (s_axi_bvalid),
		.s_axi_bready             (s_axi_bready),
		.s_axi_araddr             (s_axi_araddr),
		.s_axi_arvalid            (s_axi_arvalid),
		.s_axi_arready            (s_axi_arready),
		.s_axi_rdata              (s_axi_rdata),
		.s_axi_rresp              (s_axi_rresp),
		.s_axi_rvalid             (s_axi_rvalid),
		.s_axi_rready             (s_axi_rready),
		.global_averaging_enable  (global_averaging_enable),
		.lane_averaging_select    (lane_averaging_select),
		.lane_averaging_effective (lane_averaging_effective),
		.ch1_cfg                  (ch1_cfg)
	);

	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// ----------------------------------------------------------------
	// checks and bus tasks
	// ----------------------------------------------------------------
	task automatic chk_val(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_resp(input string what, input logic [1:0] exp,
		input logic [1:0] got);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d,
		input logic [3:0] s, input logic [1:0] er);
		logic aw_left;
		logic w_left;
		int   n;
		aw_left = 1'b1;
		w_left = 1'b1;
		n = 0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {16'h0000, d};
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge mclk);
			n++;
			if (aw_left && s_axi_awready === 1'b1)
			begin
				aw_left = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w_left && s_axi_wready === 1'b1)
			begin
				w_left = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		while ((aw_left || w_left) && n < 40);
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (s_axi_bvalid !== 1'b1 && n < 80);
		s_axi_bready <= 1'b0;
		chk_val("bvalid", 32'h1, {31'h0, s_axi_bvalid});
		chk_resp("bresp", er, s_axi_bresp);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (s_axi_arready !== 1'b1 && n < 40);
		s_axi_arvalid <= 1'b0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (s_axi_rvalid !== 1'b1 && n < 80);
		s_axi_rready <= 1'b0;
		chk_val("rdata", {16'h0000, exp}, s_axi_rdata);
		chk_resp("rresp", er, s_axi_rresp);
	endtask

	function automatic aafr_lanes_t lanes_of(input logic [15:0] lo,
		input logic [15:0] hi);
		return {hi[10:9], hi[7:6], hi[4:3], hi[1:0],
			lo[10:9], lo[7:6], lo[4:3], lo[1:0]};
	endfunction

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge mclk);
		fails++;
		wrap_up();
	end

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial
	begin
		aafr_lanes_t exp_l;
		logic [15:0] v;
		fails = 0;
		num_checks = 0;
		rst <= 1'b1;
		s_axi_awaddr <= 8'h00;
		s_axi_awvalid <= 1'b0;
		s_axi_wdata <= 32'h00000000;
		s_axi_wstrb <= 4'h0;
		s_axi_wvalid <= 1'b0;
		s_axi_bready <= 1'b0;
		s_axi_araddr <= 8'h00;
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b0;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		chk_val("ch1_cfg", 32'h0, {19'h0, ch1_cfg});
		rd_chk(8'hB8, CH1_RESET, RESP_OKAY);
		for (int i = 0; i < 2; i++)
		begin
			wr(8'hB0, lo_tab[i], 4'hF, RESP_OKAY);
			wr(8'hB4, hi_tab[i], 4'hF, RESP_OKAY);
			rd_chk(8'hB0, lo_tab[i] & AVG_WR_MASK, RESP_OKAY);
			rd_chk(8'hB4, hi_tab[i] & AVG_WR_MASK, RESP_OKAY);
			exp_l = lanes_of(lo_tab[i], hi_tab[i]);
			chk_val("lanes", {16'h0, exp_l},
				{16'h0, lane_averaging_select});
			chk_val("effective", 32'h0,
				{16'h0, lane_averaging_effective});
		end
		wr(8'hA4, 16'hFFFF, 4'hF, RESP_OKAY);
		@(posedge mclk);
		chk_val("global", 32'h1,
			{31'h0, global_averaging_enable});
		chk_val("effective", {16'h0, exp_l},
			{16'h0, lane_averaging_effective});
		rd_chk(8'hA4, 16'h0001, RESP_OKAY);
		rd_chk(8'hFC, exp_l, RESP_OKAY);
		wr(8'hA4, 16'h0000, 4'hF, RESP_OKAY);
		@(posedge mclk);
		chk_val("effective", 32'h0,
			{16'h0, lane_averaging_effective});
		chk_val("lanes", {16'h0, exp_l},
			{16'h0, lane_averaging_select});
		for (int i = 0; i < 4; i++)
		begin
			v = ch1_tab[i];
			wr(8'hB8, v, 4'hF, RESP_OKAY);
			rd_chk(8'hB8, v & CH1_WR_MASK, RESP_OKAY);
			chk_val("ch1_cfg",
				{19'h0, v[14], v[13:10], v[9:7], v[6:4], v[2], v[0]},
				{19'h0, ch1_cfg});
		end
		// partial strobes keep the unstrobed byte
		wr(8'hB8, 16'h0000, 4'h1, RESP_OKAY);
		rd_chk(8'hB8, 16'h6A00, RESP_OKAY);
		wr(8'hB8, 16'hFFFF, 4'h2, RESP_OKAY);
		rd_chk(8'hB8, 16'h7F00, RESP_OKAY);
		// unmapped and read-only places refuse
		wr(8'h00, 16'hFFFF, 4'hF, RESP_SLVERR);
		wr(8'hFC, 16'hFFFF, 4'hF, RESP_SLVERR);
		rd_chk(8'h00, 16'h0000, RESP_SLVERR);
		rd_chk(8'hA8, 16'h0000, RESP_SLVERR);
		rd_chk(8'hB8, 16'h7F00, RESP_OKAY);
		// second reset in mid-run
		@(posedge mclk);
		rst <= 1'b1;
		repeat (3) @(posedge mclk);
		chk_val("ch1_cfg", 32'h0, {19'h0, ch1_cfg});
		rst <= 1'b0;
		rd_chk(8'hB8, CH1_RESET, RESP_OKAY);
		wrap_up();
	end
endmodule

`default_nettype wire
